// ==== rtl/onps_pkg.sv ====
package onps_pkg;

    // Register offsets; the bus carries the printed offsets directly.
    localparam logic [11:0] ADDR_THRESH_FIRST  = 12'h211;
    localparam logic [11:0] ADDR_THRESH_SECOND = 12'h212;
    localparam logic [11:0] ADDR_PIN_CONFIG    = 12'h213;
    localparam logic [11:0] ADDR_SOURCE_MODE   = 12'h214;
    localparam logic [11:0] ADDR_PRESET_SELECT = 12'h215;
    localparam logic [11:0] ADDR_IRQ_STATUS    = 12'h2B0;
    localparam logic [11:0] ADDR_IRQ_MASK      = 12'h2B1;
    localparam logic [11:0] ADDR_NCO_BASE      = 12'h220;

    // Values after reset.
    localparam logic [7:0]  RST_THRESH_FIRST   = 8'hF2;
    localparam logic [7:0]  RST_THRESH_SECOND  = 8'hAB;
    localparam logic [7:0]  RST_PIN_CONFIG     = 8'h07;
    localparam logic [7:0]  RST_SOURCE_MODE    = 8'h00;
    localparam logic [7:0]  RST_PRESET_SELECT  = 8'h00;
    localparam logic [31:0] RST_NCO_FREQ       = 32'hC0000000;
    localparam logic [15:0] RST_NCO_PHASE      = 16'h0000;

    // Field positions.
    localparam int POS_PIN_ENABLE     = 3;
    localparam int POS_SEL_A_LO       = 0;
    localparam int POS_SEL_B_LO       = 2;
    localparam int STRETCH_BASE_LOG2  = 3;
    localparam int FLAG_WIDTH         = 2;

    // Preset source modes.
    localparam logic [1:0] MODE_REGISTER  = 2'h0;
    localparam logic [1:0] MODE_SPLIT_PIN = 2'h1;
    localparam logic [1:0] MODE_SHARED_PIN = 2'h2;

    // Pulse stretcher phases.
    typedef enum logic [1:0] {
        ONPS_IDLE    = 2'b01,
        ONPS_HOLDING = 2'b10
    } onps_stretch_state_t;

endpackage : onps_pkg

// ==== rtl/onps_chan_if.sv ====
`timescale 1ns/100ps
interface onps_chan_if;
    logic [11:0] sample_mag;
    logic [7:0]  thresh_first;
    logic [7:0]  thresh_second;
    logic [2:0]  stretch_exp;
    logic        sample_valid;
    logic [1:0]  flag_now;
    logic [1:0]  flag_held;

    modport ctrl (output sample_mag, output thresh_first, output thresh_second,
                  output stretch_exp, output sample_valid, input flag_now, input flag_held);
    modport det  (input sample_mag, input thresh_first, input thresh_second,
                  input stretch_exp, input sample_valid, output flag_now, output flag_held);
endinterface : onps_chan_if

// ==== rtl/onps_detector.sv ====
`timescale 1ns/100ps
module onps_detector
    import onps_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst,
    // Channel link.
    onps_chan_if.det  ch
);
    typedef struct packed {
        onps_stretch_state_t st;
        logic [10:0]         cnt;
        logic [1:0]          held;
        logic [1:0]          now;
    } onps_det_state_t;

    onps_det_state_t s_ff;
    onps_det_state_t nxt_s;
    logic [1:0]      hit;
    logic [10:0]     span;

    // Magnitude is 12 bits; the 8-bit threshold compares against the top 8 bits.
    always_comb begin
        hit[0] = ch.sample_valid && (ch.sample_mag[11:4] >= ch.thresh_first);
        hit[1] = ch.sample_valid && (ch.sample_mag[11:4] >= ch.thresh_second);
        // Widened before the add, since exponent 7 plus 3 does not fit in three bits.
        span   = 11'(1) << (4'(ch.stretch_exp) + 4'(STRETCH_BASE_LOG2));
    end

    // A new hit restarts the window, so pulses never end early.
    always_comb begin
        nxt_s     = s_ff;
        nxt_s.now = hit;
        case (s_ff.st)
            ONPS_IDLE: begin
                if (|hit) begin
                    nxt_s.st   = ONPS_HOLDING;
                    nxt_s.held = hit;
                    nxt_s.cnt  = span;
                end
            end
            ONPS_HOLDING: begin
                if (|hit) begin
                    nxt_s.held = s_ff.held | hit;
                    nxt_s.cnt  = span;
                end else if (s_ff.cnt == 11'(1)) begin
                    nxt_s.st   = ONPS_IDLE;
                    nxt_s.held = 2'h0;
                    nxt_s.cnt  = 11'(0);
                end else begin
                    nxt_s.cnt  = s_ff.cnt - 11'(1);
                end
            end
            default: nxt_s.st = ONPS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_ff <= '{st: ONPS_IDLE, cnt: 11'h000, held: 2'h0, now: 2'h0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign ch.flag_now  = s_ff.now;
    assign ch.flag_held = s_ff.held;
endmodule : onps_detector

// ==== rtl/onps_top.sv ====
`timescale 1ns/100ps
module onps_top
    import onps_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port.
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Sample magnitudes and embedded status.
    input  wire logic [11:0] chan_a_sample_mag,
    input  wire logic [11:0] chan_b_sample_mag,
    input  wire logic        sample_valid,
    input  wire logic        serial_link_enable,
    output logic      [1:0]  chan_a_embedded_flags,
    output logic      [1:0]  chan_b_embedded_flags,
    // Overrange pins.
    output logic             chan_a_over_flag0_pin,
    output logic             chan_a_over_flag1_pin,
    output logic             chan_b_over_flag0_pin,
    output logic             chan_b_over_flag1_pin,
    // Preset pins.
    input  wire logic [1:0]  chan_a_preset_pins,
    input  wire logic [1:0]  chan_b_preset_pins,
    // Active NCO settings.
    output logic      [31:0] chan_a_nco_frequency,
    output logic      [15:0] chan_a_nco_phase,
    output logic      [31:0] chan_b_nco_frequency,
    output logic      [15:0] chan_b_nco_phase,
    output logic      [1:0]  chan_a_active_preset,
    output logic      [1:0]  chan_b_active_preset,
    // Interrupt.
    output logic             irq
);
    typedef struct packed {
        logic [7:0]       thr0;
        logic [7:0]       thr1;
        logic [7:0]       pcfg;
        logic [7:0]       mode;
        logic [7:0]       psel;
        logic [3:0]       irq_stat;
        logic [3:0]       irq_mask;
        logic [7:0]       rdata;
        logic [1:0]       pa_s1;
        logic [1:0]       pa_s2;
        logic [1:0]       pb_s1;
        logic [1:0]       pb_s2;
        logic [1:0]       sel_a;
        logic [1:0]       sel_b;
        logic [3:0][31:0] freq_a;
        logic [3:0][15:0] ph_a;
        logic [3:0][31:0] freq_b;
        logic [3:0][15:0] ph_b;
        logic [31:0]      fa;
        logic [15:0]      pa;
        logic [31:0]      fb;
        logic [15:0]      pb;
    } onps_state_t;

    localparam onps_state_t RST_STATE = '{
        thr0:    RST_THRESH_FIRST,
        thr1:    RST_THRESH_SECOND,
        pcfg:    RST_PIN_CONFIG,
        mode:    RST_SOURCE_MODE,
        psel:    RST_PRESET_SELECT,
        freq_a:  {4{RST_NCO_FREQ}},
        freq_b:  {4{RST_NCO_FREQ}},
        ph_a:    {4{RST_NCO_PHASE}},
        ph_b:    {4{RST_NCO_PHASE}},
        fa:      RST_NCO_FREQ,
        fb:      RST_NCO_FREQ,
        default: '0
    };

    onps_state_t s_ff;
    onps_state_t nxt_s;

    onps_chan_if ch_a ();
    onps_chan_if ch_b ();

    // Byte index of an NCO word: 16 bytes per preset, A presets then B.
    function automatic logic nco_hit(input logic [11:0] a, input logic b_side,
                                     input logic [1:0] p, input logic [3:0] lo, input logic [3:0] hi);
        logic [11:0] base;
        base    = ADDR_NCO_BASE + {5'h00, b_side, p, 4'h0};
        nco_hit = (a >= base + {8'h00, lo}) && (a <= base + {8'h00, hi});
    endfunction : nco_hit

    assign ch_a.sample_mag    = chan_a_sample_mag;
    assign ch_b.sample_mag    = chan_b_sample_mag;
    assign ch_a.thresh_first  = s_ff.thr0;
    assign ch_b.thresh_first  = s_ff.thr0;
    assign ch_a.thresh_second = s_ff.thr1;
    assign ch_b.thresh_second = s_ff.thr1;
    assign ch_a.stretch_exp   = s_ff.pcfg[2:0];
    assign ch_b.stretch_exp   = s_ff.pcfg[2:0];
    assign ch_a.sample_valid  = sample_valid;
    assign ch_b.sample_valid  = sample_valid;

    onps_detector u_det_a (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ch      (ch_a)
    );

    onps_detector u_det_b (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ch      (ch_b)
    );

    always_comb begin
        logic [3:0] ev;
        logic [1:0] byte_i;
        nxt_s      = s_ff;
        ev         = {ch_b.flag_now, ch_a.flag_now};
        byte_i     = 2'h0;
        nxt_s.rdata = 8'h00;

        // Pins come from another domain, so two flops before use.
        nxt_s.pa_s1 = chan_a_preset_pins;
        nxt_s.pa_s2 = s_ff.pa_s1;
        nxt_s.pb_s1 = chan_b_preset_pins;
        nxt_s.pb_s2 = s_ff.pb_s1;

        if (reg_wr) begin
            if (reg_addr == ADDR_THRESH_FIRST) begin
                nxt_s.thr0 = reg_wdata;
            end else if (reg_addr == ADDR_THRESH_SECOND) begin
                nxt_s.thr1 = reg_wdata;
            end else if (reg_addr == ADDR_PIN_CONFIG) begin
                nxt_s.pcfg = reg_wdata;
            end else if (reg_addr == ADDR_SOURCE_MODE) begin
                nxt_s.mode = reg_wdata;
            end else if (reg_addr == ADDR_PRESET_SELECT) begin
                nxt_s.psel = reg_wdata;
            end else if (reg_addr == ADDR_IRQ_STATUS) begin
                nxt_s.irq_stat = s_ff.irq_stat & ~reg_wdata[3:0];
            end else if (reg_addr == ADDR_IRQ_MASK) begin
                nxt_s.irq_mask = reg_wdata[3:0];
            end
            for (int p = 0; p < 4; p++) begin
                byte_i = reg_addr[1:0];
                if (nco_hit(reg_addr, 1'b0, 2'(p), 4'h0, 4'h3))
                    nxt_s.freq_a[p][8*byte_i +: 8] = reg_wdata;
                if (nco_hit(reg_addr, 1'b1, 2'(p), 4'h0, 4'h3))
                    nxt_s.freq_b[p][8*byte_i +: 8] = reg_wdata;
                if (nco_hit(reg_addr, 1'b0, 2'(p), 4'h4, 4'h5))
                    nxt_s.ph_a[p][8*byte_i[0] +: 8] = reg_wdata;
                if (nco_hit(reg_addr, 1'b1, 2'(p), 4'h4, 4'h5))
                    nxt_s.ph_b[p][8*byte_i[0] +: 8] = reg_wdata;
            end
        end
        // Set beats clear when both land in one cycle.
        nxt_s.irq_stat = nxt_s.irq_stat | ev;

        if (reg_rd) begin
            if (reg_addr == ADDR_THRESH_FIRST) begin
                nxt_s.rdata = s_ff.thr0;
            end else if (reg_addr == ADDR_THRESH_SECOND) begin
                nxt_s.rdata = s_ff.thr1;
            end else if (reg_addr == ADDR_PIN_CONFIG) begin
                nxt_s.rdata = s_ff.pcfg;
            end else if (reg_addr == ADDR_SOURCE_MODE) begin
                nxt_s.rdata = s_ff.mode;
            end else if (reg_addr == ADDR_PRESET_SELECT) begin
                nxt_s.rdata = s_ff.psel;
            end else if (reg_addr == ADDR_IRQ_STATUS) begin
                nxt_s.rdata = {4'h0, s_ff.irq_stat};
            end else if (reg_addr == ADDR_IRQ_MASK) begin
                nxt_s.rdata = {4'h0, s_ff.irq_mask};
            end
            for (int p = 0; p < 4; p++) begin
                byte_i = reg_addr[1:0];
                if (nco_hit(reg_addr, 1'b0, 2'(p), 4'h0, 4'h3))
                    nxt_s.rdata = s_ff.freq_a[p][8*byte_i +: 8];
                if (nco_hit(reg_addr, 1'b1, 2'(p), 4'h0, 4'h3))
                    nxt_s.rdata = s_ff.freq_b[p][8*byte_i +: 8];
                if (nco_hit(reg_addr, 1'b0, 2'(p), 4'h4, 4'h5))
                    nxt_s.rdata = s_ff.ph_a[p][8*byte_i[0] +: 8];
                if (nco_hit(reg_addr, 1'b1, 2'(p), 4'h4, 4'h5))
                    nxt_s.rdata = s_ff.ph_b[p][8*byte_i[0] +: 8];
            end
        end

        // Reserved mode 3 keeps the previous choice rather than guessing.
        case (s_ff.mode[1:0])
            MODE_REGISTER: begin
                nxt_s.sel_a = s_ff.psel[POS_SEL_A_LO +: 2];
                nxt_s.sel_b = s_ff.psel[POS_SEL_B_LO +: 2];
            end
            MODE_SPLIT_PIN: begin
                nxt_s.sel_a = s_ff.pa_s2;
                nxt_s.sel_b = s_ff.pb_s2;
            end
            MODE_SHARED_PIN: begin
                nxt_s.sel_a = s_ff.pa_s2;
                nxt_s.sel_b = s_ff.pa_s2;
            end
            default: begin
                nxt_s.sel_a = s_ff.sel_a;
            end
        endcase
        nxt_s.fa = s_ff.freq_a[s_ff.sel_a];
        nxt_s.pa = s_ff.ph_a[s_ff.sel_a];
        nxt_s.fb = s_ff.freq_b[s_ff.sel_b];
        nxt_s.pb = s_ff.ph_b[s_ff.sel_b];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_ff <= RST_STATE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Pins are decoded from held flags so downstream logic sees clean stretched pulses.
    always_comb begin
        logic en;
        en = s_ff.pcfg[POS_PIN_ENABLE];
        chan_a_over_flag0_pin = en & ch_a.flag_held[0];
        chan_a_over_flag1_pin = en & ch_a.flag_held[1];
        chan_b_over_flag0_pin = en & ch_b.flag_held[0];
        chan_b_over_flag1_pin = en & ch_b.flag_held[1];
    end

    assign chan_a_embedded_flags = ch_a.flag_now;
    assign chan_b_embedded_flags = ch_b.flag_now;
    assign reg_rdata             = s_ff.rdata;
    assign chan_a_nco_frequency  = s_ff.fa;
    assign chan_a_nco_phase      = s_ff.pa;
    assign chan_b_nco_frequency  = s_ff.fb;
    assign chan_b_nco_phase      = s_ff.pb;
    assign chan_a_active_preset  = s_ff.sel_a;
    assign chan_b_active_preset  = s_ff.sel_b;
    assign irq                   = |(s_ff.irq_stat & s_ff.irq_mask);

    logic unused_link;
    assign unused_link = serial_link_enable;
endmodule : onps_top

// ==== verification/onps_top_asserts.sv ====
`timescale 1ns/100ps
module onps_asserts
    import onps_pkg::*;
(
    // Clock, reset and register port.
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    // Channel side.
    input wire logic [1:0]  chan_a_embedded_flags,
    input wire logic        chan_a_over_flag0_pin,
    input wire logic        chan_a_over_flag1_pin,
    input wire logic        chan_b_over_flag0_pin,
    input wire logic        chan_b_over_flag1_pin,
    // Preset side.
    input wire logic [1:0]  chan_a_preset_pins,
    input wire logic [1:0]  chan_b_preset_pins,
    input wire logic [1:0]  chan_a_active_preset,
    input wire logic [1:0]  chan_b_active_preset,
    input wire logic        irq
);
    logic [7:0]  cfg_ff;
    logic [7:0]  mode_ff;
    logic [7:0]  sel_ff;
    logic [7:0]  mask_ff;
    logic [11:0] hi_ff;
    wire  [3:0]  pins = {chan_a_over_flag0_pin, chan_a_over_flag1_pin, chan_b_over_flag0_pin, chan_b_over_flag1_pin};
    // Shadow copies of the registers, so the checks need no view inside the block.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_ff  <= RST_PIN_CONFIG;
            mode_ff <= RST_SOURCE_MODE;
            sel_ff  <= RST_PRESET_SELECT;
            mask_ff <= 8'h00;
            hi_ff   <= 12'h000;
        end else begin
            if (reg_wr && reg_addr == ADDR_PIN_CONFIG) cfg_ff <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_SOURCE_MODE) mode_ff <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_PRESET_SELECT) sel_ff <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_IRQ_MASK) mask_ff <= reg_wdata;
            hi_ff <= chan_a_over_flag0_pin ? hi_ff + 12'h001 : 12'h000;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_pins_gated: assert property (
        !cfg_ff[3] && !$past(cfg_ff[3]) |-> pins == 4'h0) else $error("pins driven while disabled");
    a_flag_a_pin: assert property (
        $rose(chan_a_embedded_flags[0]) && cfg_ff[3] |-> ##[0:1] chan_a_over_flag0_pin) else $error("A0 pin missing");
    a_flag_a1_pin: assert property (
        $rose(chan_a_embedded_flags[1]) && cfg_ff[3] |-> ##[0:1] chan_a_over_flag1_pin) else $error("A1 pin missing");
    a_pulse_stretch: assert property (
        $fell(chan_a_over_flag0_pin) && cfg_ff[3] |-> hi_ff >= (12'h008 << cfg_ff[2:0])) else $error("pulse short");
    a_reg_select: assert property (
        (mode_ff == 8'h00 && $stable(sel_ff) && $stable(mode_ff))[*4]
        |-> chan_a_active_preset == sel_ff[1:0] && chan_b_active_preset == sel_ff[3:2]) else $error("reg select");
    a_split_pins: assert property (
        (mode_ff == 8'h01 && $stable(mode_ff) && $stable(chan_a_preset_pins) && $stable(chan_b_preset_pins))[*6]
        |-> chan_a_active_preset == chan_a_preset_pins && chan_b_active_preset == chan_b_preset_pins)
        else $error("split pins");
    a_shared_pins: assert property (
        (mode_ff == 8'h02 && $stable(mode_ff) && $stable(chan_a_preset_pins))[*6]
        |-> chan_a_active_preset == chan_a_preset_pins && chan_b_active_preset == chan_a_preset_pins)
        else $error("shared pins");
    a_irq_masked: assert property (
        mask_ff == 8'h00 && $past(mask_ff) == 8'h00 |-> !irq) else $error("irq while masked");
endmodule : onps_asserts
bind onps_top onps_asserts u_asserts (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .chan_a_embedded_flags,
    .chan_a_over_flag0_pin, .chan_a_over_flag1_pin, .chan_b_over_flag0_pin, .chan_b_over_flag1_pin,
    .chan_a_preset_pins, .chan_b_preset_pins, .chan_a_active_preset, .chan_b_active_preset, .irq);

// ==== verification/onps_host_model.sv ====
`timescale 1ns/100ps
module onps_host_model (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Wanted presets and watched pin.
    input  wire logic [1:0]  req_a,
    input  wire logic [1:0]  req_b,
    input  wire logic        chan_a_over_flag0_pin,
    // Driven pins and last pulse length.
    output logic      [1:0]  chan_a_preset_pins,
    output logic      [1:0]  chan_b_preset_pins,
    output logic      [11:0] pulse_len
);
    logic [11:0] run_ff;
    // Pins move just after an edge, like a host register output.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            chan_a_preset_pins <= 2'h0;
            chan_b_preset_pins <= 2'h0;
            run_ff             <= 12'h000;
            pulse_len          <= 12'h000;
        end else begin
            chan_a_preset_pins <= req_a;
            chan_b_preset_pins <= req_b;
            run_ff <= chan_a_over_flag0_pin ? run_ff + 12'h001 : 12'h000;
            if (!chan_a_over_flag0_pin && run_ff != 12'h000) pulse_len <= run_ff;
        end
    end
endmodule : onps_host_model

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
    import onps_pkg::*;
;
    logic clk_sys, rst, reg_wr, reg_rd, sample_valid, serial_link_enable, irq;
    logic chan_a_over_flag0_pin, chan_a_over_flag1_pin, chan_b_over_flag0_pin, chan_b_over_flag1_pin;
    logic [11:0] reg_addr, chan_a_sample_mag, chan_b_sample_mag, pulse_len;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [1:0]  req_a, req_b, chan_a_preset_pins, chan_b_preset_pins, chan_a_active_preset, chan_b_active_preset;
    logic [1:0]  chan_a_embedded_flags, chan_b_embedded_flags;
    logic [31:0] chan_a_nco_frequency, chan_b_nco_frequency;
    logic [15:0] chan_a_nco_phase, chan_b_nco_phase;
    int          fails, cmp_count;
    logic [3:0]  emb_q;
    wire  [3:0]  pins = {chan_a_over_flag0_pin, chan_a_over_flag1_pin, chan_b_over_flag0_pin, chan_b_over_flag1_pin};
    wire  [3:0]  emb = {chan_a_embedded_flags, chan_b_embedded_flags};
    wire  [99:0] nco = {chan_a_active_preset, chan_b_active_preset, chan_a_nco_frequency, chan_a_nco_phase,
                        chan_b_nco_frequency, chan_b_nco_phase};
    localparam logic [7:0]  RST_TAB [6] = '{8'hF2, 8'hAB, 8'h07, 8'h00, 8'h00, 8'h00};
    localparam logic [99:0] E0 = {4'h0, RST_NCO_FREQ, RST_NCO_PHASE, RST_NCO_FREQ, RST_NCO_PHASE};
    localparam logic [99:0] E1 = {4'h9, 32'h12345678, 16'hBEEF, 32'h0BADF00D, 16'h1357};
    localparam logic [99:0] E2 = {4'hA, 32'h12345678, 16'hBEEF, RST_NCO_FREQ, RST_NCO_PHASE};
    onps_top u_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chan_a_sample_mag,
        .chan_b_sample_mag, .sample_valid, .serial_link_enable, .chan_a_embedded_flags, .chan_b_embedded_flags,
        .chan_a_over_flag0_pin, .chan_a_over_flag1_pin, .chan_b_over_flag0_pin, .chan_b_over_flag1_pin,
        .chan_a_preset_pins, .chan_b_preset_pins, .chan_a_nco_frequency, .chan_a_nco_phase, .chan_b_nco_frequency,
        .chan_b_nco_phase, .chan_a_active_preset, .chan_b_active_preset, .irq);
    onps_host_model u_host (.clk_sys, .rst, .req_a, .req_b, .chan_a_over_flag0_pin, .chan_a_preset_pins,
        .chan_b_preset_pins, .pulse_len);
    task chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle
    // One valid sample per channel; the embedded flags stand for one cycle only, so they are caught then.
    task hit(input logic [11:0] a, input logic [11:0] b);
        @(posedge clk_sys);
        chan_a_sample_mag <= a;
        chan_b_sample_mag <= b;
        sample_valid      <= 1'b1;
        @(posedge clk_sys);
        sample_valid      <= 1'b0;
        #1 emb_q = emb;
        settle;
    endtask : hit
    task t_reset_regs;
        for (int i = 0; i < 6; i++) begin
            rd(ADDR_THRESH_FIRST + 12'(i));
            chk("reset value", d, RST_TAB[i]);
        end
    endtask : t_reset_regs
    task t_thresholds;
        wr(ADDR_PIN_CONFIG, 8'h08);
        hit(12'hF20, 12'hF1F);
        chk("pins", pins, 4'hD);
        chk("embedded", emb_q, 4'hE);
        repeat (20) @(posedge clk_sys);
        wr(ADDR_THRESH_SECOND, 8'h10);
        hit(12'h100, 12'h0FF);
        chk("low pins", pins, 4'h4);
        chk("low embedded", emb_q, 4'h8);
        repeat (20) @(posedge clk_sys);
    endtask : t_thresholds
    task t_pin_enable;
        wr(ADDR_PIN_CONFIG, 8'h00);
        hit(12'hF20, 12'hF20);
        chk("pins off", pins, 4'h0);
        chk("embedded on", emb_q, 4'hF);
        repeat (20) @(posedge clk_sys);
    endtask : t_pin_enable
    task t_stretch;
        @(posedge clk_sys);
        serial_link_enable <= 1'b0;
        for (int e = 0; e < 2; e++) begin
            wr(ADDR_PIN_CONFIG, {5'h01, 3'(e)});
            hit(12'hF20, 12'h000);
            repeat (40) @(posedge clk_sys);
            chk("pulse min", pulse_len >= (12'h008 << e), 1'b1);
            chk("pulse doubling", pulse_len < (12'h010 << e), 1'b1);
        end
    endtask : t_stretch
    task t_irq;
        wr(ADDR_IRQ_STATUS, 8'h0F);
        wr(ADDR_IRQ_MASK, 8'h01);
        hit(12'hF20, 12'h000);
        settle;
        chk("irq raised", irq, 1'b1);
        repeat (20) @(posedge clk_sys);
        rd(ADDR_IRQ_STATUS);
        chk("status", d, 8'h03);
        wr(ADDR_IRQ_STATUS, 8'h01);
        settle;
        chk("irq cleared", irq, 1'b0);
        rd(ADDR_IRQ_STATUS);
        chk("status left", d, 8'h02);
    endtask : t_irq
    task nco_set(input logic [11:0] b, input logic [31:0] f, input logic [15:0] p);
        for (int i = 0; i < 6; i++) wr(b + 12'(i), i < 4 ? f[8 * i +: 8] : p[8 * (i - 4) +: 8]);
    endtask : nco_set
    task set_mode(input logic [7:0] m, input logic [1:0] ra, input logic [1:0] rb);
        @(posedge clk_sys);
        req_a <= ra;
        req_b <= rb;
        wr(ADDR_SOURCE_MODE, m);
        repeat (8) @(posedge clk_sys);
        #1;
    endtask : set_mode
    task t_presets;
        nco_set(ADDR_NCO_BASE + 12'h020, 32'h12345678, 16'hBEEF);
        nco_set(ADDR_NCO_BASE + 12'h050, 32'h0BADF00D, 16'h1357);
        @(posedge clk_sys);
        serial_link_enable <= 1'b1;
        set_mode(8'h00, 2'h1, 2'h3);
        chk("preset zero", nco, E0);
        wr(ADDR_PRESET_SELECT, 8'h06);
        set_mode(8'h00, 2'h1, 2'h3);
        chk("register select", nco, E1);
        set_mode(8'h01, 2'h2, 2'h1);
        chk("split pins", nco, E1);
        set_mode(8'h02, 2'h2, 2'h0);
        chk("shared pins", nco, E2);
        set_mode(8'h03, 2'h0, 2'h3);
        chk("reserved mode", nco, E2);
    endtask : t_presets
    task end_sim;
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        end_sim;
    end
    initial begin
        {fails, cmp_count} = '0;
        {rst, reg_wr, reg_rd, sample_valid, serial_link_enable} = 5'h10;
        {reg_addr, reg_wdata, chan_a_sample_mag, chan_b_sample_mag, req_a, req_b} = '0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_regs;
        t_thresholds;
        t_pin_enable;
        t_stretch;
        t_irq;
        t_presets;
        end_sim;
    end
endmodule : tb_top
